/* bench/mise_tb.sv */
// Self-checking bench for the instruction-subset execution core.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import mise_pkg::*;
    logic           clk;
    logic           arst_n;
    logic           instr_valid;
    logic [IW-1:0]  instr;
    logic [DW-1:0]  hi_latch;
    logic           instr_ready;
    logic [DW-1:0]  accumulator;
    logic           result_null_flag;
    logic           pc_load;
    logic [PCW-1:0] pc_target;
    logic           no_operation_exec;
    logic           fr_wr_en;
    logic [FAW-1:0] fr_wr_addr;
    logic [DW-1:0]  fr_wr_data;
    int             miscompares;
    int             checked;

    mise_core DUT (
        .clk                        (clk),
        .arst_n                     (arst_n),
        .instr_valid                (instr_valid),
        .instr                      (instr),
        .program_counter_high_latch (hi_latch),
        .instr_ready                (instr_ready),
        .accumulator                (accumulator),
        .result_null_flag           (result_null_flag),
        .pc_load                    (pc_load),
        .pc_target                  (pc_target),
        .no_operation_exec          (no_operation_exec),
        .fr_wr_en                   (fr_wr_en),
        .fr_wr_addr                 (fr_wr_addr),
        .fr_wr_data                 (fr_wr_data)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task results;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    task check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [IW-1:0] fw(input logic [2:0] opc,
                                         input logic d,
                                         input logic [FAW-1:0] f);
        return {opc, 3'h0, d, f};
    endfunction : fw

    function automatic logic [IW-1:0] lw(input logic [DW-1:0] k);
        return {OPC_OR_LIT, 3'h0, k};
    endfunction : lw

    // Valid stays high between words so back-to-back takes are exercised;
    // while ready is low the held word must be ignored.
    task send(input logic [IW-1:0] w);
        int i;
        i = 0;
        while (instr_ready !== 1'b1 && i < 20) begin
            @(posedge clk);
            #1;
            i++;
        end
        // Judge by ready itself, so a late ready on the last try still counts.
        if (instr_ready !== 1'b1) begin
            miscompares++;
            $display("Error at %0t: core never ready", $time);
            results;
        end else begin
            instr_valid = 1'b1;
            instr = w;
            @(posedge clk);
            #1;
        end
    endtask : send

    task run(input logic [IW-1:0] w, input logic two, input logic no_operation);
        send(w);
        if (two) begin
            check(instr_ready, 1'b0);
            @(posedge clk);
            #1;
            check(instr_ready, 1'b1);
        end
        check(no_operation_exec, no_operation);
    endtask : run

    task t_clear;
        run(lw(8'h5A), 1'b0, 1'b0);
        check(accumulator, 8'h5A);
        check(result_null_flag, 1'b0);
        run(fw(OPC_CLR_ACC, 1'b0, 7'h00), 1'b0, 1'b0);
        check(accumulator, 8'h00);
        check(result_null_flag, 1'b1);
        run(lw(8'h81), 1'b0, 1'b0);
        check(result_null_flag, 1'b0);
        run(lw(8'h04), 1'b0, 1'b0);
        check(accumulator, 8'h85);
        run(fw(OPC_CLR_FILE, 1'b0, 7'h10), 1'b0, 1'b0);
        check(fr_wr_en, 1'b1);
        check(fr_wr_addr, 7'h10);
        check(fr_wr_data, 8'h00);
        check(result_null_flag, 1'b1);
        check(accumulator, 8'h85);
        $display("t_clear done");
    endtask : t_clear

    task t_dec;
        run(fw(OPC_CLR_FILE, 1'b1, 7'h20), 1'b0, 1'b0);
        run(fw(OPC_DEC_FILE, 1'b1, 7'h20), 1'b1, 1'b0);
        check(fr_wr_en, 1'b1);
        check(fr_wr_addr, 7'h20);
        check(fr_wr_data, 8'hFF);
        check(result_null_flag, 1'b0);
        check(accumulator, 8'h85);
        run(fw(OPC_DEC_FILE, 1'b0, 7'h20), 1'b1, 1'b0);
        check(accumulator, 8'hFE);
        check(fr_wr_en, 1'b0);
        run(fw(OPC_INC_SKIP, 1'b1, 7'h20), 1'b1, 1'b0);
        check(fr_wr_data, 8'h00);
        check(result_null_flag, 1'b0);
        run(lw(8'hFF), 1'b0, 1'b1);
        check(accumulator, 8'hFE);
        run(fw(OPC_INC_SKIP, 1'b1, 7'h20), 1'b1, 1'b0);
        check(fr_wr_data, 8'h01);
        run(lw(8'h01), 1'b0, 1'b0);
        check(accumulator, 8'hFF);
        run(fw(OPC_DEC_FILE, 1'b0, 7'h20), 1'b1, 1'b0);
        check(accumulator, 8'h00);
        check(result_null_flag, 1'b1);
        $display("t_dec done");
    endtask : t_dec

    task t_skip;
        run(fw(OPC_CLR_FILE, 1'b1, 7'h30), 1'b0, 1'b0);
        run(fw(OPC_INC_SKIP, 1'b1, 7'h30), 1'b1, 1'b0);
        run(fw(OPC_INC_SKIP, 1'b1, 7'h30), 1'b1, 1'b0);
        run(fw(OPC_DEC_SKIP, 1'b1, 7'h30), 1'b1, 1'b0);
        check(fr_wr_data, 8'h01);
        check(result_null_flag, 1'b1);
        run(lw(8'h30), 1'b0, 1'b0);
        check(accumulator, 8'h30);
        run(fw(OPC_DEC_SKIP, 1'b0, 7'h30), 1'b1, 1'b0);
        check(accumulator, 8'h00);
        check(fr_wr_en, 1'b0);
        check(result_null_flag, 1'b0);
        run(lw(8'h0F), 1'b0, 1'b1);
        check(accumulator, 8'h00);
        run(fw(OPC_DEC_SKIP, 1'b1, 7'h30), 1'b1, 1'b0);
        check(fr_wr_data, 8'h00);
        run(lw(8'h0F), 1'b0, 1'b1);
        run(fw(OPC_DEC_SKIP, 1'b1, 7'h30), 1'b1, 1'b0);
        check(fr_wr_data, 8'hFF);
        run(lw(8'h0F), 1'b0, 1'b0);
        check(accumulator, 8'h0F);
        $display("t_skip done");
    endtask : t_skip

    task jmp(input logic [DW-1:0] l, input logic [KJW-1:0] k,
             input logic [PCW-1:0] t);
        hi_latch = l;
        run({OPC_JUMP_ABS, k}, 1'b0, 1'b0);
        check(pc_load, 1'b1);
        check(pc_target, t);
        check(result_null_flag, 1'b0);
        run(lw(8'hF0), 1'b0, 1'b1);
        check(pc_load, 1'b0);
        check(accumulator, 8'h0F);
    endtask : jmp

    task t_jump;
        // Unused latch bits are set so any leak into the target shows.
        jmp(8'hE7, 11'h7FF, 13'h07FF);
        jmp(8'h18, 11'h000, 13'h1800);
        run(fw(OPC_CLR_ACC, 1'b0, 7'h00), 1'b0, 1'b0);
        run({OPC_JUMP_ABS, 11'h2AA}, 1'b0, 1'b0);
        check(result_null_flag, 1'b1);
        run({OPC_JUMP_ABS, 11'h123}, 1'b0, 1'b1);
        check(pc_load, 1'b0);
        check(pc_target, 13'h1AAA);
        $display("t_jump done");
    endtask : t_jump

    // A reset in mid-run must clear the accumulator; the OR of zero then
    // also exercises the zero path of the flag.
    task t_reset;
        run(lw(8'h3C), 1'b0, 1'b0);
        check(accumulator, 8'h3C);
        instr_valid = 1'b0;
        arst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        arst_n = 1'b1;
        run(lw(8'h00), 1'b0, 1'b0);
        check(accumulator, 8'h00);
        check(result_null_flag, 1'b1);
        $display("t_reset done");
    endtask : t_reset

    initial begin
        miscompares = 0;
        checked = 0;
        arst_n = 1'b0;
        instr_valid = 1'b0;
        instr = '0;
        hi_latch = 8'h00;
        repeat (20) @(posedge clk);
        #1;
        arst_n = 1'b1;
        t_clear;
        t_dec;
        t_skip;
        t_jump;
        t_reset;
        results;
    end
endmodule : testbench
`default_nettype wire

/* src/mise_alu.sv */
// Eight-bit arithmetic unit for decrement, increment, OR and clear.
`timescale 1ns/1ns
`default_nettype none
module mise_alu
    import mise_pkg::*;
(
    input  wire mise_alu_op_t  op,
    input  wire logic [DW-1:0] a,
    input  wire logic [DW-1:0] b,
    output logic [DW-1:0]      res,
    output logic               zero
);
    always_comb begin
        case (op)
            ALU_DEC: res = DW'(a - ONE_BYTE);
            ALU_INC: res = DW'(a + ONE_BYTE);
            ALU_OR:  res = a | b;
            default: res = ZERO_BYTE;
        endcase
        zero = (res == ZERO_BYTE);
    end
endmodule : mise_alu
`default_nettype wire

/* src/mise_core.sv */
// Execution core for the clear, decrement, skip, jump and OR-literal subset.
`timescale 1ns/1ns
`default_nettype none
module mise_core
    import mise_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           arst_n,
    input  wire logic           instr_valid,
    input  wire logic [IW-1:0]  instr,
    input  wire logic [DW-1:0]  program_counter_high_latch,
    output logic                instr_ready,
    output logic [DW-1:0]       accumulator,
    output logic                result_null_flag,
    output logic                pc_load,
    output logic [PCW-1:0]      pc_target,
    output logic                no_operation_exec,
    output logic                fr_wr_en,
    output logic [FAW-1:0]      fr_wr_addr,
    output logic [DW-1:0]       fr_wr_data
);
    mise_state_t    state;
    mise_state_t    next_state;
    logic [2:0]     op_q;
    logic [FAW-1:0] f_q;
    logic           d_q;
    logic [2:0]     opc;
    logic           take;
    logic           needs_read;
    logic           in_exec;
    logic           skip_op;
    mise_alu_op_t   alu_op;
    logic [DW-1:0]  alu_a;
    logic [DW-1:0]  alu_res;
    logic           alu_zero;

    mise_fr_if fr ();

    mise_fr_mem u_mem (
        .clk    (clk),
        .arst_n (arst_n),
        .fr     (fr)
    );

    mise_alu u_alu (
        .op   (alu_op),
        .a    (alu_a),
        .b    (instr[K_LIT_HI:0]),
        .res  (alu_res),
        .zero (alu_zero)
    );

    assign opc        = instr[OPC_HI:OPC_LO];
    assign take       = (state == ST_TAKE) && instr_valid;
    assign in_exec    = (state == ST_EXEC);
    assign needs_read = (opc == OPC_DEC_FILE) || (opc == OPC_DEC_SKIP)
                        || (opc == OPC_INC_SKIP);
    assign skip_op    = (op_q == OPC_DEC_SKIP) || (op_q == OPC_INC_SKIP);

    always_comb begin
        alu_op = ALU_CLR;
        alu_a  = accumulator;
        if (in_exec) begin
            alu_a  = fr.rd_data;
            alu_op = (op_q == OPC_INC_SKIP) ? ALU_INC : ALU_DEC;
        end else if (opc == OPC_OR_LIT) begin
            alu_op = ALU_OR;
        end
    end

    // The read is issued while taking the word; data is ready in execute.
    assign fr.rd_en   = take && needs_read;
    assign fr.rd_addr = instr[F_HI:0];

    always_comb begin
        fr.wr_en   = 1'b0;
        fr.wr_addr = instr[F_HI:0];
        fr.wr_data = ZERO_BYTE;
        if (in_exec) begin
            fr.wr_en   = d_q;
            fr.wr_addr = f_q;
            fr.wr_data = alu_res;
        end else if (take && opc == OPC_CLR_FILE) begin
            fr.wr_en = 1'b1;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_TAKE: begin
                if (take && opc == OPC_JUMP_ABS) begin
                    next_state = ST_FLUSH;
                end else if (take && needs_read) begin
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                next_state = (skip_op && alu_zero) ? ST_FLUSH : ST_TAKE;
            end
            ST_FLUSH: begin
                if (instr_valid) begin
                    next_state = ST_TAKE;
                end
            end
            default: next_state = ST_TAKE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state       <= ST_TAKE;
            instr_ready <= 1'b1;
        end else begin
            state       <= next_state;
            instr_ready <= (next_state != ST_EXEC);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            op_q <= OPC_NO_OP;
            f_q  <= ADDR_ZERO;
            d_q  <= 1'b0;
        end else if (take) begin
            op_q <= opc;
            f_q  <= instr[F_HI:0];
            d_q  <= instr[D_BIT];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            accumulator <= ZERO_BYTE;
        end else if (take && opc == OPC_CLR_ACC) begin
            accumulator <= ZERO_BYTE;
        end else if (take && opc == OPC_OR_LIT) begin
            accumulator <= alu_res;
        end else if (in_exec && !d_q) begin
            accumulator <= alu_res;
        end
    end

    // Skip and jump leave the flag alone, so only four cases touch it.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            result_null_flag <= 1'b0;
        end else if (take && (opc == OPC_CLR_FILE || opc == OPC_CLR_ACC)) begin
            result_null_flag <= 1'b1;
        end else if (take && opc == OPC_OR_LIT) begin
            result_null_flag <= alu_zero;
        end else if (in_exec && op_q == OPC_DEC_FILE) begin
            result_null_flag <= alu_zero;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_load   <= 1'b0;
            pc_target <= PC_RESET;
        end else begin
            pc_load <= take && (opc == OPC_JUMP_ABS);
            if (take && opc == OPC_JUMP_ABS) begin
                pc_target <= {program_counter_high_latch[PCH_HI:PCH_LO],
                              instr[K_JMP_HI:0]};
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            no_operation_exec <= 1'b0;
        end else begin
            no_operation_exec <= (state == ST_FLUSH) && instr_valid;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fr_wr_en   <= 1'b0;
            fr_wr_addr <= ADDR_ZERO;
            fr_wr_data <= ZERO_BYTE;
        end else begin
            fr_wr_en   <= fr.wr_en;
            fr_wr_addr <= fr.wr_addr;
            fr_wr_data <= fr.wr_data;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_clr_file;
        take && opc == OPC_CLR_FILE |=> fr_wr_en && fr_wr_data == ZERO_BYTE
            && fr_wr_addr == $past(instr[F_HI:0]) && result_null_flag;
    endproperty
    a_clr_file: assert property (p_clr_file)
        else $error("clear file register did not write zero and set flag");

    property p_clr_acc;
        take && opc == OPC_CLR_ACC |=> accumulator == ZERO_BYTE
            && result_null_flag;
    endproperty
    a_clr_acc: assert property (p_clr_acc)
        else $error("clear accumulator did not zero it and set flag");

    property p_dec_file;
        in_exec && op_q == OPC_DEC_FILE && d_q |=> fr_wr_en
            && fr_wr_data == DW'($past(fr.rd_data) - ONE_BYTE)
            && result_null_flag == (fr_wr_data == ZERO_BYTE);
    endproperty
    a_dec_file: assert property (p_dec_file)
        else $error("decrement to file wrote a wrong value or flag");

    property p_dec_skip;
        in_exec && op_q == OPC_DEC_SKIP && fr.rd_data == ONE_BYTE |=>
            state == ST_FLUSH && $stable(result_null_flag) ##1
            (state == ST_FLUSH || no_operation_exec);
    endproperty
    a_dec_skip: assert property (p_dec_skip)
        else $error("decrement skip on zero did not insert a skip cycle");

    property p_dec_noskip;
        in_exec && op_q == OPC_DEC_SKIP && fr.rd_data != ONE_BYTE |=>
            state == ST_TAKE && instr_ready;
    endproperty
    a_dec_noskip: assert property (p_dec_noskip)
        else $error("decrement skip with nonzero result skipped anyway");

    property p_inc_skip;
        in_exec && op_q == OPC_INC_SKIP && fr.rd_data == MAX_BYTE |=>
            state == ST_FLUSH && $stable(result_null_flag);
    endproperty
    a_inc_skip: assert property (p_inc_skip)
        else $error("increment skip wrapping to zero did not skip");

    property p_jump_target;
        take && opc == OPC_JUMP_ABS |=> pc_load && pc_target ==
            {$past(program_counter_high_latch[PCH_HI:PCH_LO]),
             $past(instr[K_JMP_HI:0])};
    endproperty
    a_jump_target: assert property (p_jump_target)
        else $error("jump target differs from latch bits and literal");

    property p_jump_two;
        take && opc == OPC_JUMP_ABS |=> state == ST_FLUSH
            && $stable(result_null_flag) ##1 !pc_load;
    endproperty
    a_jump_two: assert property (p_jump_two)
        else $error("jump did not take two cycles or changed the flag");

    property p_or_lit;
        take && opc == OPC_OR_LIT |=> accumulator ==
            ($past(accumulator) | $past(instr[K_LIT_HI:0]))
            && result_null_flag == (accumulator == ZERO_BYTE);
    endproperty
    a_or_lit: assert property (p_or_lit)
        else $error("OR literal gave a wrong accumulator or flag");

    property p_discard;
        state == ST_FLUSH && instr_valid |=> no_operation_exec
            && $stable(accumulator) && !fr_wr_en && !pc_load;
    endproperty
    a_discard: assert property (p_discard)
        else $error("skipped instruction was not discarded");

    property p_dec_wrap;
        in_exec && op_q != OPC_INC_SKIP && d_q && fr.rd_data == ZERO_BYTE
            |=> fr_wr_data == MAX_BYTE;
    endproperty
    a_dec_wrap: assert property (p_dec_wrap)
        else $error("decrement from zero did not wrap to 255");
endmodule : mise_core
`default_nettype wire

/* src/mise_fr_if.sv */
// File-register port bundle between the core and its register memory.
`timescale 1ns/1ns
`default_nettype none
interface mise_fr_if;
    import mise_pkg::*;
    logic           rd_en;
    logic [FAW-1:0] rd_addr;
    logic [DW-1:0]  rd_data;
    logic           wr_en;
    logic [FAW-1:0] wr_addr;
    logic [DW-1:0]  wr_data;
    modport core (output rd_en, output rd_addr, input rd_data,
                  output wr_en, output wr_addr, output wr_data);
    modport mem  (input rd_en, input rd_addr, output rd_data,
                  input wr_en, input wr_addr, input wr_data);
endinterface : mise_fr_if
`default_nettype wire

/* src/mise_fr_mem.sv */
// File-register memory with one write port and a registered read port.
`timescale 1ns/1ns
`default_nettype none
module mise_fr_mem
    import mise_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    mise_fr_if.mem    fr
);
    logic [DW-1:0] mem [0:(1<<FAW)-1];

    // The array has no reset, so software must clear what it relies on.
    always_ff @(posedge clk) begin
        if (fr.wr_en) begin
            mem[fr.wr_addr] <= fr.wr_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fr.rd_data <= ZERO_BYTE;
        end else if (fr.rd_en) begin
            fr.rd_data <= mem[fr.rd_addr];
        end
    end
endmodule : mise_fr_mem
`default_nettype wire

/* src/mise_pkg.sv */
// Constants, encodings and types shared by the instruction-subset core.
// Functional notes
// - Clearing a file register writes zero there and sets the null flag.
// - Clearing the accumulator loads zero and sets the null flag.
// - Decrement file register; result to accumulator (d=0) or file (d=1).
// - Decrement-skip stores result, keeps flags, skips next on zero.
// - Decrement-skip with nonzero result lets the next instruction run.
// - Increment-skip stores result, keeps flags, skips next on zero.
// - Jump loads its eleven-bit literal into counter bits 10 to 0.
// - Jump fills counter bits 12 and 11 from latch bits 4 and 3.
// - Jump takes two cycles and leaves all flags unchanged.
// - OR an eight-bit literal into the accumulator, update null flag.
// - Without a skip flow is unchanged; skipped word is discarded.
package mise_pkg;
    localparam int DW  = 8;
    localparam int FAW = 7;
    localparam int IW  = 14;
    localparam int PCW = 13;
    localparam int KJW = 11;

    localparam int OPC_HI   = 13;
    localparam int OPC_LO   = 11;
    localparam int D_BIT    = 7;
    localparam int F_HI     = 6;
    localparam int K_LIT_HI = 7;
    localparam int K_JMP_HI = 10;
    localparam int PCH_HI   = 4;
    localparam int PCH_LO   = 3;

    localparam logic [2:0] OPC_NO_OP      = 3'h0;
    localparam logic [2:0] OPC_CLR_FILE   = 3'h1;
    localparam logic [2:0] OPC_CLR_ACC    = 3'h2;
    localparam logic [2:0] OPC_DEC_FILE   = 3'h3;
    localparam logic [2:0] OPC_DEC_SKIP   = 3'h4;
    localparam logic [2:0] OPC_JUMP_ABS   = 3'h5;
    localparam logic [2:0] OPC_OR_LIT     = 3'h6;
    localparam logic [2:0] OPC_INC_SKIP   = 3'h7;

    localparam logic [DW-1:0]  ZERO_BYTE = 8'h00;
    localparam logic [DW-1:0]  ONE_BYTE  = 8'h01;
    localparam logic [DW-1:0]  MAX_BYTE  = 8'hFF;
    localparam logic [PCW-1:0] PC_RESET  = 13'h0000;
    localparam logic [FAW-1:0] ADDR_ZERO = 7'h00;

    typedef enum logic [2:0] {
        ST_TAKE  = 3'b001,
        ST_EXEC  = 3'b010,
        ST_FLUSH = 3'b100
    } mise_state_t;

    typedef enum logic [1:0] {
        ALU_DEC = 2'h0,
        ALU_INC = 2'h1,
        ALU_OR  = 2'h2,
        ALU_CLR = 2'h3
    } mise_alu_op_t;
endpackage : mise_pkg
